// File: hw/blecx_pkg.sv
// Summary of operation
// - receive indication mode: 00 correlator on, 01 with power-up, 10 priority
// - transmit indication mode: 00 without power-up, 01 with it, 10 priority
// - wlan_tx effect field: 00 none, 01 stop tx, 10 stop rx, 11 both
// - wlan_rx effect field, same coding, resets to 01 (stops tx only)
// - sync pulse goes out only while sync pulse enable is set
// - coexistence enable bit, reset 0, turns the whole interface on or off
// - receive mode 10: rx priority high when traffic priority exceeds rx threshold
// - transmit mode 10: tx priority high when traffic priority exceeds tx threshold
// - hold time in us keeps priority shown; zero holds until enable falls
// - lead delay in us from enable rise until priority is shown
// - per-activity priorities: passive 3, nonconn adv 4, conn adv 8, active 9
// - further priorities: initiating A, data D, link control E, conn request F
// - fallback priority, reset 3, for any other message type
package blecx_pkg;
	// register byte addresses
	localparam logic [31:0] ADDR_MODE = 32'h4000_0100;
	localparam logic [31:0] ADDR_TIMING = 32'h4000_0104;
	localparam logic [31:0] ADDR_TABLE = 32'h4000_0108;
	localparam logic [31:0] ADDR_FALLBACK = 32'h4000_010C;
	// values after reset
	localparam logic [31:0] RST_MODE = 32'h0000_0010;
	localparam logic [31:0] RST_TIMING = 32'h0000_0000;
	localparam logic [31:0] RST_TABLE = 32'h3489_ADEF;
	localparam logic [31:0] RST_FALLBACK = 32'h3000_0000;
	// writable bits of each register
	localparam logic [31:0] MASK_MODE = 32'h0033_00F3;
	localparam logic [31:0] MASK_TIMING = 32'h1F1F_7F7F;
	localparam logic [31:0] MASK_TABLE = 32'hFFFF_FFFF;
	localparam logic [31:0] MASK_FALLBACK = 32'hF000_0000;
	// field positions (low bit)
	localparam int RX_MODE_LSB = 20;
	localparam int TX_MODE_LSB = 16;
	localparam int WLAN_TX_EFF_LSB = 6;
	localparam int WLAN_RX_EFF_LSB = 4;
	localparam int SYNC_EN_BIT = 1;
	localparam int COEXISTENCE_ENABLE_BIT = 0;
	localparam int RX_THR_LSB = 24;
	localparam int TX_THR_LSB = 16;
	localparam int HOLD_LSB = 8;
	localparam int DELAY_LSB = 0;
	localparam int FALLBACK_LSB = 28;
	// indication modes
	localparam logic [1:0] IND_NO_PWRUP = 2'h0;
	localparam logic [1:0] IND_WITH_PWRUP = 2'h1;
	localparam logic [1:0] IND_PRIORITY = 2'h2;
	// timing: one microsecond in pclk cycles
	localparam int US_NS = 1000;
	localparam int CLK_PERIOD_NS = 50;
	localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
	// priority timer states
	typedef enum logic [2:0] {
		TS_IDLE = 3'h1,
		TS_WAIT = 3'h2,
		TS_SHOW = 3'h4
	} blecx_tstate_t;
endpackage

// File: hw/blecx_tim_if.sv
`timescale 1ns/1ns
`default_nettype none
// link between the register side and one priority timer
interface blecx_tim_if;
	logic en;
	logic high;
	logic tick;
	logic [6:0] delay;
	logic [6:0] hold;
	logic out;
	modport ctl (output en, output high, output tick, output delay,
		output hold, input out);
	modport tim (input en, input high, input tick, input delay,
		input hold, output out);
endinterface
`default_nettype wire

// File: hw/blecx_prio_timer.sv
`timescale 1ns/1ns
`default_nettype none
// lead delay and hold window for one priority indication
module blecx_prio_timer (
	input wire logic pclk,
	input wire logic presetn,
	blecx_tim_if.tim t
);
	typedef struct packed {
		blecx_pkg::blecx_tstate_t st;
		logic [6:0] cnt;
		logic en_d;
		logic out;
	} blecx_tstate_s_t;

	blecx_tstate_s_t s_r;
	blecx_tstate_s_t s_nxt;

	// next state: wait delay after enable rise, then show for hold time
	always_comb begin
		s_nxt = s_r;
		s_nxt.en_d = t.en;
		unique case (s_r.st)
			blecx_pkg::TS_IDLE: begin
				if (t.en && !s_r.en_d) begin
					if (t.delay == 7'h00) begin
						s_nxt.st = blecx_pkg::TS_SHOW;
						s_nxt.cnt = t.hold;
					end else begin
						s_nxt.st = blecx_pkg::TS_WAIT;
						s_nxt.cnt = t.delay;
					end
				end
			end
			blecx_pkg::TS_WAIT: begin
				if (!t.en) begin
					s_nxt.st = blecx_pkg::TS_IDLE;
				end else if (t.tick) begin
					if (s_r.cnt == 7'h01) begin
						s_nxt.st = blecx_pkg::TS_SHOW;
						s_nxt.cnt = t.hold;
					end else begin
						s_nxt.cnt = s_r.cnt - 7'h01;
					end
				end
			end
			blecx_pkg::TS_SHOW: begin
				if (s_r.cnt == 7'h00) begin
					if (!t.en) begin
						s_nxt.st = blecx_pkg::TS_IDLE;
					end
				end else if (t.tick) begin
					if (s_r.cnt == 7'h01) begin
						s_nxt.st = blecx_pkg::TS_IDLE;
					end
					s_nxt.cnt = s_r.cnt - 7'h01;
				end
			end
			default: begin
				s_nxt.st = blecx_pkg::TS_IDLE;
			end
		endcase
		s_nxt.out = (s_nxt.st == blecx_pkg::TS_SHOW) && t.high;
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '{st: blecx_pkg::TS_IDLE, cnt: 7'h00, en_d: 1'b0,
				out: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign t.out = s_r.out;

	// checks
	no_delay_show_a: assert property (@(posedge pclk) disable iff (!presetn)
		(s_r.st == blecx_pkg::TS_IDLE && t.en && !s_r.en_d &&
		t.delay == 7'h00) |=> s_r.st == blecx_pkg::TS_SHOW)
		else $error("zero delay did not show priority at once");
	hold_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		(s_r.st == blecx_pkg::TS_SHOW && s_r.cnt == 7'h00 && t.en)
		|=> s_r.st == blecx_pkg::TS_SHOW)
		else $error("zero hold released priority while enabled");
	out_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_r.out |-> $past(t.high))
		else $error("priority shown without high priority");
endmodule
`default_nettype wire

// File: hw/blecx_top.sv
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
// coexistence indications towards an external wlan arbiter, apb registers
module blecx_top #(
	parameter int ACT_W = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ll_tx_en,
	input wire logic ll_tx_pwrup,
	input wire logic ll_rx_en,
	input wire logic ll_rx_corr_en,
	input wire logic [ACT_W-1:0] ll_activity,
	input wire logic ll_sync_evt,
	input wire logic wlan_tx,
	input wire logic wlan_rx,
	output logic coex_tx,
	output logic coex_rx,
	output logic [3:0] coex_pti,
	output logic coex_sync,
	output logic ll_tx_stop,
	output logic ll_rx_stop
);
	typedef struct packed {
		logic [31:0] mode;
		logic [31:0] timing;
		logic [31:0] table_w;
		logic [31:0] fallback;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
		logic [4:0] us_cnt;
		logic tick;
		logic tx;
		logic rx;
		logic [3:0] pti;
		logic sync;
		logic tx_stop;
		logic rx_stop;
	} blecx_state_t;

	blecx_state_t s_r;
	blecx_state_t s_nxt;

	// field views of the control registers
	logic coexistence_enable;
	logic sync_en;
	logic [1:0] rx_mode;
	logic [1:0] tx_mode;
	logic [1:0] wtx_eff;
	logic [1:0] wrx_eff;
	logic [4:0] rx_thr;
	logic [4:0] tx_thr;
	assign coexistence_enable = s_r.mode[blecx_pkg::COEXISTENCE_ENABLE_BIT];
	assign sync_en = s_r.mode[blecx_pkg::SYNC_EN_BIT];
	assign rx_mode = s_r.mode[blecx_pkg::RX_MODE_LSB +: 2];
	assign tx_mode = s_r.mode[blecx_pkg::TX_MODE_LSB +: 2];
	assign wtx_eff = s_r.mode[blecx_pkg::WLAN_TX_EFF_LSB +: 2];
	assign wrx_eff = s_r.mode[blecx_pkg::WLAN_RX_EFF_LSB +: 2];
	assign rx_thr = s_r.timing[blecx_pkg::RX_THR_LSB +: 5];
	assign tx_thr = s_r.timing[blecx_pkg::TX_THR_LSB +: 5];

	// priority timers: index 0 for transmit, 1 for receive
	logic [1:0] tim_en;
	logic [1:0] tim_high;
	logic [1:0] tim_out;
	assign tim_en[0] = coexistence_enable && ll_tx_en;
	assign tim_en[1] = coexistence_enable && ll_rx_en;
	assign tim_high[0] = {1'b0, s_r.pti} > tx_thr;
	assign tim_high[1] = {1'b0, s_r.pti} > rx_thr;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_tim
			blecx_tim_if tif ();
			assign tif.en = tim_en[gi];
			assign tif.high = tim_high[gi];
			assign tif.tick = s_r.tick;
			assign tif.delay = s_r.timing[blecx_pkg::DELAY_LSB +: 7];
			assign tif.hold = s_r.timing[blecx_pkg::HOLD_LSB +: 7];
			assign tim_out[gi] = tif.out;
			blecx_prio_timer u_tim (
				.pclk(pclk),
				.presetn(presetn),
				.t(tif.tim)
			);
		end
	endgenerate

	// byte lanes of a write merged under the writable mask
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] strb,
		input logic [31:0] msk);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & msk;
		return (old & ~m) | (wd & m);
	endfunction

	// indication chosen by a 2-bit mode
	function automatic logic indicate(input logic [1:0] md,
		input logic plain, input logic full, input logic prio);
		logic r;
		r = 1'b0;
		if (md == blecx_pkg::IND_NO_PWRUP) begin
			r = plain;
		end else if (md == blecx_pkg::IND_WITH_PWRUP) begin
			r = full;
		end else if (md == blecx_pkg::IND_PRIORITY) begin
			r = prio;
		end
		return r;
	endfunction

	logic setup;
	logic wr;
	logic hit;
	logic [3:0] act_prio;
	assign setup = psel && !penable;
	assign wr = psel && penable && s_r.ready && pwrite;
	assign hit = paddr == blecx_pkg::ADDR_MODE ||
		paddr == blecx_pkg::ADDR_TIMING ||
		paddr == blecx_pkg::ADDR_TABLE ||
		paddr == blecx_pkg::ADDR_FALLBACK;

	// activity code picks a table nibble, other codes take fallback
	always_comb begin
		act_prio = s_r.fallback[blecx_pkg::FALLBACK_LSB +: 4];
		for (int k = 0; k < 8; k++) begin
			if (ll_activity == ACT_W'(k)) begin
				act_prio = s_r.table_w[k*4 +: 4];
			end
		end
	end

	// next state of registers, bus answer and outputs
	always_comb begin
		s_nxt = s_r;
		// apb: answer prepared in setup, given in first access cycle
		s_nxt.ready = setup;
		s_nxt.slverr = setup && !hit;
		s_nxt.rdata = 32'h0000_0000;
		if (setup && !pwrite) begin
			unique case (1'b1)
				paddr == blecx_pkg::ADDR_MODE: s_nxt.rdata = s_r.mode;
				paddr == blecx_pkg::ADDR_TIMING: s_nxt.rdata = s_r.timing;
				paddr == blecx_pkg::ADDR_TABLE: s_nxt.rdata = s_r.table_w;
				paddr == blecx_pkg::ADDR_FALLBACK: s_nxt.rdata = s_r.fallback;
				default: s_nxt.rdata = 32'h0000_0000;
			endcase
		end
		if (wr && paddr == blecx_pkg::ADDR_MODE) begin
			s_nxt.mode = merge(s_r.mode, pwdata, pstrb,
				blecx_pkg::MASK_MODE);
		end
		if (wr && paddr == blecx_pkg::ADDR_TIMING) begin
			s_nxt.timing = merge(s_r.timing, pwdata, pstrb,
				blecx_pkg::MASK_TIMING);
		end
		if (wr && paddr == blecx_pkg::ADDR_TABLE) begin
			s_nxt.table_w = merge(s_r.table_w, pwdata, pstrb,
				blecx_pkg::MASK_TABLE);
		end
		if (wr && paddr == blecx_pkg::ADDR_FALLBACK) begin
			s_nxt.fallback = merge(s_r.fallback, pwdata, pstrb,
				blecx_pkg::MASK_FALLBACK);
		end
		// microsecond tick for the priority timers
		if (s_r.us_cnt == 5'(blecx_pkg::US_CYCLES - 1)) begin
			s_nxt.us_cnt = 5'h00;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.us_cnt = s_r.us_cnt + 5'h01;
			s_nxt.tick = 1'b0;
		end
		// indications, all quiet while coexistence is off
		s_nxt.pti = coexistence_enable ? act_prio : 4'h0;
		s_nxt.tx = coexistence_enable && indicate(tx_mode, ll_tx_en && !ll_tx_pwrup,
			ll_tx_en, tim_out[0]);
		s_nxt.rx = coexistence_enable && indicate(rx_mode, ll_rx_corr_en,
			ll_rx_en, tim_out[1]);
		s_nxt.sync = coexistence_enable && sync_en && ll_sync_evt;
		s_nxt.tx_stop = coexistence_enable && ((wlan_tx && wtx_eff[0]) ||
			(wlan_rx && wrx_eff[0]));
		s_nxt.rx_stop = coexistence_enable && ((wlan_tx && wtx_eff[1]) ||
			(wlan_rx && wrx_eff[1]));
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.mode <= blecx_pkg::RST_MODE;
			s_r.timing <= blecx_pkg::RST_TIMING;
			s_r.table_w <= blecx_pkg::RST_TABLE;
			s_r.fallback <= blecx_pkg::RST_FALLBACK;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from flip-flops
	assign prdata = s_r.rdata;
	assign pready = s_r.ready;
	assign pslverr = s_r.slverr;
	assign coex_tx = s_r.tx;
	assign coex_rx = s_r.rx;
	assign coex_pti = s_r.pti;
	assign coex_sync = s_r.sync;
	assign ll_tx_stop = s_r.tx_stop;
	assign ll_rx_stop = s_r.rx_stop;

	// checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("apb answer not one access cycle");
	sync_gate_a: assert property (coex_sync |-> $past(coexistence_enable && sync_en))
		else $error("sync pulse without enable");
	off_quiet_a: assert property (!coexistence_enable && $past(!coexistence_enable) |->
		!coex_tx && !coex_rx && coex_pti == 4'h0 && !ll_tx_stop &&
		!ll_rx_stop && !coex_sync)
		else $error("indication active while disabled");
	wtx_stop_a: assert property ($past(coexistence_enable && wlan_tx && !wlan_rx &&
		wtx_eff == 2'h1) |-> ll_tx_stop && !ll_rx_stop)
		else $error("wlan_tx effect 01 wrong");
	wrx_stop_a: assert property ($past(coexistence_enable && wlan_rx && !wlan_tx &&
		wrx_eff == 2'h2) |-> ll_rx_stop && !ll_tx_stop)
		else $error("wlan_rx effect 10 wrong");
	fallback_a: assert property ($past(coexistence_enable && ll_activity >= ACT_W'(8))
		|-> coex_pti == $past(s_r.fallback[31:28]))
		else $error("fallback priority not used");
	tx_plain_a: assert property ($past(coexistence_enable && tx_mode == 2'h0) |->
		coex_tx == $past(ll_tx_en && !ll_tx_pwrup))
		else $error("tx indication mode 00 wrong");
	rx_full_a: assert property ($past(coexistence_enable && rx_mode == 2'h1) |->
		coex_rx == $past(ll_rx_en))
		else $error("rx indication mode 01 wrong");
	rx_prio_a: assert property (coex_rx && $past(rx_mode == 2'h2) |->
		$past(tim_out[1]))
		else $error("rx priority without timer");
	// further checks on indication modes, wlan effects, sync and priorities
	rx_plain_a: assert property ($past(coexistence_enable && rx_mode == 2'h0) |->
		coex_rx == $past(ll_rx_corr_en))
		else $error("rx indication mode 00 wrong");
	rx_unused_a: assert property ($past(rx_mode == 2'h3) |-> !coex_rx)
		else $error("rx indication mode 11 not quiet");
	tx_full_a: assert property ($past(coexistence_enable && tx_mode == 2'h1) |->
		coex_tx == $past(ll_tx_en))
		else $error("tx indication mode 01 wrong");
	tx_unused_a: assert property ($past(tx_mode == 2'h3) |-> !coex_tx)
		else $error("tx indication mode 11 not quiet");
	tx_prio_a: assert property ($past(coexistence_enable && tx_mode == 2'h2) |->
		coex_tx == $past(tim_out[0]))
		else $error("tx priority not from timer");
	wtx_both_a: assert property ($past(coexistence_enable && wlan_tx &&
		wtx_eff == 2'h3) |-> ll_tx_stop && ll_rx_stop)
		else $error("wlan_tx effect 11 wrong");
	wtx_none_a: assert property ($past(coexistence_enable && !wlan_rx &&
		wtx_eff == 2'h0) |-> !ll_tx_stop && !ll_rx_stop)
		else $error("wlan_tx effect 00 not quiet");
	wrx_tx_a: assert property ($past(coexistence_enable && wlan_rx &&
		!wlan_tx && wrx_eff == 2'h1) |-> ll_tx_stop && !ll_rx_stop)
		else $error("wlan_rx effect 01 wrong");
	sync_follow_a: assert property ($past(coexistence_enable && sync_en) |->
		coex_sync == $past(ll_sync_evt))
		else $error("sync pulse not copied");
	table_pick_a: assert property ($past(coexistence_enable &&
		ll_activity < ACT_W'(8)) |-> coex_pti ==
		$past(s_r.table_w[{ll_activity[2:0], 2'h0} +: 4]))
		else $error("activity priority not used");
	pti_off_a: assert property ($past(!coexistence_enable) |-> coex_pti == 4'h0)
		else $error("traffic priority shown while disabled");

	stop_seen_c: cover property (ll_tx_stop && ll_rx_stop);
	sync_seen_c: cover property (coex_sync);
	prio_tx_c: cover property (tx_mode == 2'h2 && coex_tx);
	bus_err_c: cover property (pready && pslverr);
	prio_rx_c: cover property (rx_mode == 2'h2 && coex_rx);
endmodule
`default_nettype wire

// File: verif/blecx_arb_model.sv
`timescale 1ns/1ns
`default_nettype none
// wlan arbiter stand-in: its own traffic shows on wlan_tx and wlan_rx
module blecx_arb_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic want_tx,
	input wire logic want_rx,
	input wire logic slow,
	output logic wlan_tx,
	output logic wlan_rx
);
	logic [1:0] tx_r;
	logic [1:0] rx_r;
	// two-stage lag line, the slow answer taps the second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_r <= 2'h0;
			rx_r <= 2'h0;
		end else begin
			tx_r <= {tx_r[0], want_tx};
			rx_r <= {rx_r[0], want_rx};
		end
	end
	// prompt answers one cycle after the request, slow ones two
	assign wlan_tx = slow ? tx_r[1] : tx_r[0];
	assign wlan_rx = slow ? rx_r[1] : rx_r[0];
endmodule
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, r, tbl, fb;
	logic ll_tx_en, ll_tx_pwrup, ll_rx_en, ll_rx_corr_en, ll_sync_evt;
	logic [3:0] ll_activity, coex_pti, nib;
	logic wlan_tx, wlan_rx, coex_tx, coex_rx, coex_sync;
	logic ll_tx_stop, ll_rx_stop, want_tx, want_rx, slow, probe, et, er;
	logic [65:0] nt;
	logic [65:0] exp_q[$];
	int fails, check_count, seed, i;
	localparam logic [32:0] WOK = 33'h0;
	localparam logic [32:0] M_TX = 33'h100;
	localparam logic [32:0] M_RX = 33'h80;
	localparam logic [32:0] M_PTI = 33'h78;
	localparam logic [32:0] M_SY = 33'h4;
	localparam logic [32:0] M_ST = 33'h3;

	blecx_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ll_tx_en(ll_tx_en), .ll_tx_pwrup(ll_tx_pwrup),
		.ll_rx_en(ll_rx_en), .ll_rx_corr_en(ll_rx_corr_en),
		.ll_activity(ll_activity), .ll_sync_evt(ll_sync_evt),
		.wlan_tx(wlan_tx), .wlan_rx(wlan_rx), .coex_tx(coex_tx),
		.coex_rx(coex_rx), .coex_pti(coex_pti), .coex_sync(coex_sync),
		.ll_tx_stop(ll_tx_stop), .ll_rx_stop(ll_rx_stop));
	blecx_arb_model arb (.pclk(pclk), .presetn(presetn),
		.want_tx(want_tx), .want_rx(want_rx), .slow(slow),
		.wlan_tx(wlan_tx), .wlan_rx(wlan_rx));

	// clock of 50 ns
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task print_verdict();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task check(input logic [32:0] seen, input logic [32:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one apb transfer; the note holds the answer expected for it
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d,
		input logic [32:0] e);
		int n;
		exp_q.push_back({33'h1_FFFF_FFFF, e});
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		// pready is looked at on rising edges only
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		// a used-up wait counts; the closing report follows at run end
		if (n >= 20) begin
			fails++;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		// one idle edge so the next setup never reassigns psel at once
		@(posedge pclk);
	endtask

	// let n cycles pass, then have the watcher sample the link outputs
	task look(input int n, input logic [32:0] m, input logic [32:0] e);
		exp_q.push_back({m, e});
		repeat (n) @(posedge pclk);
		probe <= 1'b1;
		@(posedge pclk);
		probe <= 1'b0;
	endtask

	function automatic logic [31:0] mword(input logic en, input logic sy,
		input logic [1:0] tm, input logic [1:0] rm, input logic [1:0] wt,
		input logic [1:0] wr);
		mword = {10'h0, rm, 2'h0, tm, 8'h0, wt, wr, 2'h0, sy, en};
	endfunction

	// watcher: each answer or sample takes the oldest note
	always @(posedge pclk) begin
		if ((psel && penable && pready) || probe) begin
			if (exp_q.size() == 0) begin
				nt = {33'h0, 33'h1};
			end else begin
				nt = exp_q.pop_front();
			end
			if (probe) begin
				check({24'h0, coex_tx, coex_rx, coex_pti, coex_sync,
					ll_tx_stop, ll_rx_stop} & nt[65:33], nt[32:0]);
			end else begin
				check({pslverr, prdata}, nt[32:0]);
			end
		end
	end

	// hang guard
	initial begin
		repeat (100000) @(posedge pclk);
		fails++;
		print_verdict();
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata, probe, slow} = '0;
		{ll_tx_en, ll_tx_pwrup, ll_rx_en, ll_rx_corr_en} = 4'h0;
		{ll_activity, ll_sync_evt, want_tx, want_rx} = 7'h0;
		seed = 41163;
		presetn = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, blecx_pkg::ADDR_MODE, 0, {1'b0, blecx_pkg::RST_MODE});
		apb(0, blecx_pkg::ADDR_TIMING, 0, WOK);
		apb(0, blecx_pkg::ADDR_TABLE, 0, {1'b0, blecx_pkg::RST_TABLE});
		apb(0, blecx_pkg::ADDR_FALLBACK, 0, {1'b0, 32'h3000_0000});
		apb(1, 32'h4000_0110, 32'hFFFF_FFFF, {1'b1, 32'h0});
		apb(0, 32'h4000_0110, 0, {1'b1, 32'h0});
		apb(1, blecx_pkg::ADDR_MODE, 32'hFFFF_FFFF, WOK);
		apb(0, blecx_pkg::ADDR_MODE, 0, {1'b0, 32'h0033_00F3});
		$display("test registers done");
		// everything asked for while coexistence is off
		apb(1, blecx_pkg::ADDR_MODE, mword(0, 1, 0, 0, 3, 3), WOK);
		{ll_tx_en, ll_rx_en, ll_rx_corr_en, ll_sync_evt} <= 4'hF;
		{want_tx, want_rx} <= 2'h3;
		look(4, 33'h1FF, 33'h0);
		$display("test disabled done");
		for (i = 0; i < 16; i++) begin
			apb(1, blecx_pkg::ADDR_MODE, mword(1, 0, 0, 0, i[3:2], i[1:0]), WOK);
			r = $random(seed);
			{slow, want_tx, want_rx} <= r[2:0];
			et = (r[1] & i[2]) | (r[0] & i[0]);
			er = (r[1] & i[3]) | (r[0] & i[1]);
			look(4, M_ST, {31'h0, et, er});
		end
		$display("test wlan effect done");
		{want_tx, want_rx} <= 2'h0;
		for (i = 0; i < 4; i++) begin
			apb(1, blecx_pkg::ADDR_MODE, mword(1, 0, i[1:0], i[1:0], 0, 0), WOK);
			r = $random(seed);
			{ll_tx_pwrup, ll_rx_corr_en, ll_sync_evt} <= r[2:0];
			// mode 10 at reset timing: no delay, held while enabled, F > 0
			et = (i == 1) || (i == 2) || (i == 0 && !r[2]);
			er = (i == 1) || (i == 2) || (i == 0 && r[1]);
			look(4, M_TX | M_RX | M_SY, {24'h0, et, er, 7'h0});
		end
		$display("test indication modes done");
		tbl = $random(seed);
		fb = $random(seed);
		apb(1, blecx_pkg::ADDR_TABLE, tbl, WOK);
		apb(1, blecx_pkg::ADDR_FALLBACK, fb, WOK);
		apb(1, blecx_pkg::ADDR_MODE, mword(1, 1, 0, 0, 0, 0), WOK);
		for (i = 0; i < 16; i++) begin
			r = $random(seed);
			ll_activity <= i[3:0];
			ll_sync_evt <= r[0];
			nib = (i < 8) ? tbl[i*4 +: 4] : fb[31:28];
			look(3, M_PTI | M_SY, {26'h0, nib, r[0], 2'h0});
		end
		$display("test priorities done");
		// priority mode: pti is F, tx threshold 14, rx threshold 15
		apb(1, blecx_pkg::ADDR_TABLE, blecx_pkg::RST_TABLE, WOK);
		ll_activity <= 4'h0;
		{ll_tx_en, ll_rx_en} <= 2'h0;
		apb(1, blecx_pkg::ADDR_TIMING, 32'h0F0E_0302, WOK);
		apb(1, blecx_pkg::ADDR_MODE, mword(1, 0, 2, 2, 0, 0), WOK);
		look(4, M_TX | M_RX, 33'h0);
		{ll_tx_en, ll_rx_en} <= 2'h3;
		look(15, M_TX | M_RX, 33'h0);
		look(28, M_TX | M_RX, M_TX);
		look(70, M_TX, 33'h0);
		{ll_tx_en, ll_rx_en} <= 2'h0;
		apb(1, blecx_pkg::ADDR_TIMING, 32'h0E0E_0000, WOK);
		look(3, M_TX | M_RX, 33'h0);
		{ll_tx_en, ll_rx_en} <= 2'h3;
		look(150, M_TX | M_RX, M_TX | M_RX);
		{ll_tx_en, ll_rx_en} <= 2'h0;
		look(2, M_TX | M_RX, 33'h0);
		$display("test priority window done");
		repeat (3) @(posedge pclk);
		print_verdict();
	end
endmodule
`default_nettype wire
